// ---- cbw_params.svh ----
// Constants for the clock buffer block-write slave: address, field positions, reset values, timing.
// Assumes inclusion by the package and the design modules of this block.
`ifndef CBW_PARAMS_SVH
`define CBW_PARAMS_SVH

`define CBW_SLAVE_ADDR      7'h69
`define CBW_CMD_CODE        8'h00
`define CBW_NUM_REG_BYTES   3
`define CBW_MAX_COUNT       8'h20
`define CBW_EN0_RESET       8'h00
`define CBW_EN1_RESET       8'h00
`define CBW_EN2_RESET       8'h00
`define CBW_B0_EN_LSB       0
`define CBW_B1_EN_LSB       4
`define CBW_B2_EN_LSB       6
`define CBW_NUM_OUTPUTS     10
`define CBW_BUS_RATE_KBPS   100

`endif

// ---- cbw_pkg.sv ----
// Types shared by the clock buffer block-write slave modules.
// Assumes cbw_params.svh is available on the include path.
`include "cbw_params.svh"

package cbw_pkg;

    // Serial protocol phase inside one frame
    typedef enum logic [4:0] {
        CBW_IDLE  = 5'b00001,
        CBW_ADDR  = 5'b00010,
        CBW_CMD   = 5'b00100,
        CBW_COUNT = 5'b01000,
        CBW_DATA  = 5'b10000
    } cbw_phase_type;

    // Enable bits as written by the controller
    typedef struct packed {
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } cbw_enables_type;

endpackage : cbw_pkg

// ---- cbw_sync.sv ----
// Three-stage synchroniser with agreement filter for one level input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps

module cbw_sync (
    input  wire logic clk,      // Destination clock
    input  wire logic rst,      // Async reset, active high
    input  wire logic async_in, // Level from another domain
    input  wire logic init_val, // Unused reset-free init is avoided
    output logic      sync_out  // Filtered level
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    // Output changes once stages two and three agree
    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    // Register chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q ^ (init_val & 1'b0);
endmodule : cbw_sync

// ---- cbw_top.sv ----
// Block-write serial slave holding per-output enables of a 1:10 clock fanout buffer.
// Assumes scl is the link clock from the controller; buf_in is the buffered clock and ref_clk is independent.
//
// Behaviour
// - Answer only address 1101001, ignore others
// - Direction bit zero is write; reads ignored
// - Receiver only, no transmit of data
// - Works at 100 kbit/s bus rate
// - Every serial byte is eight bits
// - Data bytes stored ascending from byte zero
// - Early stop keeps received, others unchanged
// - Count covers only following data bytes
// - Acknowledge every received byte on data line
// - Tristate low floats outputs; else gated clock
// - Byte 0 bits 3..0 enable outputs 3..0
// - Byte 1 high nibble, byte 2 bits 7..6
// - Bits taken MSB first, bytes 0,1,2
`timescale 1ns/100ps
`include "cbw_params.svh"

module cbw_top (
    input  wire logic       ref_clk,       // System clock, 125 MHz
    input  wire logic       rst,           // Async reset, active high
    input  wire logic       scl,           // Serial clock from controller (link clock)
    input  wire logic       sda_in,        // Serial data line level
    output logic            sda_out,       // Serial data drive value (always low)
    output logic            sda_oe_n,      // Low while pulling data line low
    input  wire logic       buf_in,        // Clock to be fanned out
    input  wire logic       output_enable, // Global tristate, high enables outputs
    output logic [9:0]      fanout_clock_outputs,    // Buffered clock outputs
    output logic [9:0]      fanout_clock_outputs_oe_n, // Low while driving each output
    output logic [9:0]      per_output_enable_bit,  // Applied enables, in ref_clk domain
    output logic            frame_busy      // Addressed frame in progress, ref_clk domain
);
    // Link-domain state (clocked by scl)
    cbw_pkg::cbw_phase_type phase_q, phase_d;
    logic [3:0]  bit_cnt_q, bit_cnt_d;
    logic [7:0]  shift_q, shift_d;
    logic [7:0]  count_q, count_d;
    logic [5:0]  data_idx_q, data_idx_d;
    logic        ack_q, ack_d;
    logic        act_q, act_d;
    cbw_pkg::cbw_enables_type regs_q, regs_d;
    logic        upd_tgl_q, upd_tgl_d;

    // Start and stop are sensed on data-line edges while scl high
    logic start_tgl_q, stop_tgl_q;
    logic start_seen_q;

    // Start condition: data falls while clock high
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tgl_q <= 1'b0;
        end else if (scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // Stop condition: data rises while clock high
    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            stop_tgl_q <= 1'b0;
        end else if (scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    logic start_pend, stop_pend_q, stop_ack_q;
    assign start_pend = start_tgl_q ^ start_seen_q;

    // Function: decode of the full data-register byte index
    function automatic logic idx_in_map(input logic [5:0] idx);
        idx_in_map = (idx < 6'(`CBW_NUM_REG_BYTES));
    endfunction : idx_in_map

    // Next-state of the receiver, evaluated at each scl rising edge
    always_comb begin
        phase_d    = phase_q;
        bit_cnt_d  = bit_cnt_q;
        shift_d    = shift_q;
        count_d    = count_q;
        data_idx_d = data_idx_q;
        act_d      = act_q;
        regs_d     = regs_q;
        upd_tgl_d  = upd_tgl_q;
        if (start_pend) begin
            // Start edge also carries the first address bit
            phase_d   = cbw_pkg::CBW_ADDR;
            shift_d   = {7'h00, sda_in};
            bit_cnt_d = 4'h1;
            act_d     = 1'b0;
        end else if (stop_pend_q) begin
            phase_d = cbw_pkg::CBW_IDLE;
        end else if (ack_q) begin
            bit_cnt_d = 4'h0;                                         // ack bit clock, no data
        end else if (phase_q != cbw_pkg::CBW_IDLE) begin
            shift_d   = {shift_q[6:0], sda_in};
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
                case (phase_q)
                    cbw_pkg::CBW_ADDR: begin
                        if ({shift_q[6:0], sda_in} == {`CBW_SLAVE_ADDR, 1'b0}) begin
                            act_d   = 1'b1;
                            phase_d = cbw_pkg::CBW_CMD;
                        end else begin
                            phase_d = cbw_pkg::CBW_IDLE;
                        end
                    end
                    cbw_pkg::CBW_CMD: begin
                        phase_d = cbw_pkg::CBW_COUNT;                 // command value not checked
                    end
                    cbw_pkg::CBW_COUNT: begin
                        count_d    = {shift_q[6:0], sda_in};
                        data_idx_d = 6'h00;
                        phase_d    = cbw_pkg::CBW_DATA;
                    end
                    cbw_pkg::CBW_DATA: begin
                        if (idx_in_map(data_idx_q)) begin
                            case (data_idx_q[1:0])
                                2'h0:    regs_d.byte0 = {shift_q[6:0], sda_in};
                                2'h1:    regs_d.byte1 = {shift_q[6:0], sda_in};
                                default: regs_d.byte2 = {shift_q[6:0], sda_in};
                            endcase
                            upd_tgl_d = ~upd_tgl_q;
                        end                                           // beyond map: dropped
                        if (data_idx_q != 6'h3F) begin
                            data_idx_d = data_idx_q + 6'h01;
                        end
                    end
                    default: phase_d = cbw_pkg::CBW_IDLE;
                endcase
            end
        end
    end

    // Acknowledge requested after eighth bit of an addressed byte
    always_comb begin
        ack_d = 1'b0;
        if (!start_pend && !stop_pend_q && !ack_q && bit_cnt_q == 4'h7) begin
            if (phase_q == cbw_pkg::CBW_ADDR) begin
                ack_d = ({shift_q[6:0], sda_in} == {`CBW_SLAVE_ADDR, 1'b0});
            end else if (phase_q != cbw_pkg::CBW_IDLE) begin
                ack_d = 1'b1;
            end
        end
    end

    // Link-domain registers on scl itself, so the bus is never oversampled by ref_clk
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            phase_q      <= cbw_pkg::CBW_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            count_q      <= 8'h00;
            data_idx_q   <= 6'h00;
            ack_q        <= 1'b0;
            act_q        <= 1'b0;
            regs_q       <= {`CBW_EN2_RESET, `CBW_EN1_RESET, `CBW_EN0_RESET};
            upd_tgl_q    <= 1'b0;
            start_seen_q <= 1'b0;
            stop_ack_q   <= 1'b0;
        end else begin
            phase_q      <= phase_d;
            bit_cnt_q    <= bit_cnt_d;
            shift_q      <= shift_d;
            count_q      <= count_d;
            data_idx_q   <= data_idx_d;
            ack_q        <= ack_d;
            act_q        <= act_d;
            regs_q       <= regs_d;
            upd_tgl_q    <= upd_tgl_d;
            start_seen_q <= start_tgl_q;
            stop_ack_q   <= stop_tgl_q;
        end
    end

    // Stop noted until next scl edge consumes it
    assign stop_pend_q = stop_tgl_q ^ stop_ack_q;

    // Acknowledge drive changes on scl falling edge
    logic ack_drv_q;
    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            ack_drv_q <= 1'b0;
        end else begin
            ack_drv_q <= ack_q;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~ack_drv_q;

    // Crossing: update toggle into ref_clk, then sample stable enable bytes
    logic upd_sync, upd_seen_q, upd_seen_d;
    logic busy_sync;
    cbw_sync u_upd_sync (
        .clk      (ref_clk),
        .rst      (rst),
        .async_in (upd_tgl_q),
        .init_val (1'b0),
        .sync_out (upd_sync)
    );
    cbw_sync u_busy_sync (
        .clk      (ref_clk),
        .rst      (rst),
        .async_in (act_q),
        .init_val (1'b0),
        .sync_out (busy_sync)
    );

    // Buffered clock level, filtered into ref_clk domain
    logic buf_lvl;
    cbw_sync u_buf_sync (
        .clk      (ref_clk),
        .rst      (rst),
        .async_in (buf_in),
        .init_val (1'b0),
        .sync_out (buf_lvl)
    );

    logic [9:0] staged_q, staged_d, applied_q, applied_d;
    logic       pend_q, pend_d;
    logic       buf_prev_q, buf_prev_d;

    // Capture new enables on toggle; apply just after the filtered clock falls.
    // The filtered level lags the pin by four cycles, so only its falling edge
    // proves the pin is still low; the pin half period must exceed five cycles.
    always_comb begin
        upd_seen_d = upd_sync;
        buf_prev_d = buf_lvl;
        staged_d   = staged_q;
        pend_d     = pend_q;
        applied_d  = applied_q;
        if (upd_sync != upd_seen_q) begin
            staged_d = {regs_q.byte2[`CBW_B2_EN_LSB +: 2],
                        regs_q.byte1[`CBW_B1_EN_LSB +: 4],
                        regs_q.byte0[`CBW_B0_EN_LSB +: 4]};
            pend_d   = 1'b1;
        end else if (pend_q && buf_prev_q && !buf_lvl) begin
            applied_d = staged_q;
            pend_d    = 1'b0;
        end
    end

    // Enable registers in ref_clk domain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            upd_seen_q <= 1'b0;
            buf_prev_q <= 1'b0;
            staged_q   <= 10'h000;
            pend_q     <= 1'b0;
            applied_q  <= 10'h000;
        end else begin
            upd_seen_q <= upd_seen_d;
            buf_prev_q <= buf_prev_d;
            staged_q   <= staged_d;
            pend_q     <= pend_d;
            applied_q  <= applied_d;
        end
    end

    // Stop toggle into ref_clk, so a frame ends even with scl parked high
    logic stop_sync;
    cbw_sync u_stop_sync (
        .clk      (ref_clk),
        .rst      (rst),
        .async_in (stop_tgl_q),
        .init_val (1'b0),
        .sync_out (stop_sync)
    );

    logic stop_seen_q, stop_seen_d;
    logic ended_q, ended_d;
    logic busy_q, busy_d;

    // Busy while an addressed frame runs; a stop ends it until the next start
    always_comb begin
        stop_seen_d = stop_sync;
        ended_d     = ended_q;
        if (stop_sync != stop_seen_q) begin
            ended_d = 1'b1;                                           // Stop wins over clear
        end else if (!busy_sync) begin
            ended_d = 1'b0;
        end
        busy_d = busy_sync & ~ended_d;
    end

    // Busy registers in ref_clk domain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_seen_q <= 1'b0;
            ended_q     <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            stop_seen_q <= stop_seen_d;
            ended_q     <= ended_d;
            busy_q      <= busy_d;
        end
    end

    // Output gating of the buffered clock
    assign fanout_clock_outputs      = {`CBW_NUM_OUTPUTS{buf_in}} & applied_q;
    assign fanout_clock_outputs_oe_n = {`CBW_NUM_OUTPUTS{~output_enable}};
    assign per_output_enable_bit     = applied_q;
    assign frame_busy                = busy_q;
endmodule : cbw_top

// ---- cbw_properties.sv ----
// Port checker for the block-write slave.
// Assumes binding to cbw_top; scl clocks the serial side.
`timescale 1ns/100ps

module cbw_properties (
    input wire logic       ref_clk,                   // System clock
    input wire logic       rst,                       // Reset
    input wire logic       scl,                       // Link clock
    input wire logic       sda_in,                    // Data line
    input wire logic       sda_out,                   // Drive value
    input wire logic       sda_oe_n,                  // Ack pull
    input wire logic       buf_in,                    // Fanned clock
    input wire logic       output_enable,             // Global enable
    input wire logic [9:0] fanout_clock_outputs,      // Outputs
    input wire logic [9:0] fanout_clock_outputs_oe_n, // Output enables
    input wire logic [9:0] per_output_enable_bit,     // Enables
    input wire logic       frame_busy                 // Frame flag
);
    logic [5:0] idle_q;
    logic [5:0] idle_d;

    // Cycles since the last addressed frame
    always_comb idle_d = frame_busy ? 6'h00 : ((idle_q == 6'h3F) ? idle_q : idle_q + 6'h01);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) idle_q <= 6'h00;
        else idle_q <= idle_d;
    end

    a_oe_tristate: assert property (@(posedge ref_clk) disable iff (rst)
        fanout_clock_outputs_oe_n == {10{!output_enable}}) else $error("output enables wrong");
    a_out_gated: assert property (@(posedge ref_clk) disable iff (rst)
        fanout_clock_outputs == ({10{buf_in}} & per_output_enable_bit)) else $error("outputs not gated");
    a_no_runt: assert property (@(posedge ref_clk) disable iff (rst)
        buf_in && $past(buf_in) |-> $stable(fanout_clock_outputs)) else $error("output cut while high");
    a_sda_low: assert property (@(posedge ref_clk) disable iff (rst)
        sda_out == 1'b0) else $error("data drive not low");
    a_reset_state: assert property (@(posedge ref_clk)
        rst |-> per_output_enable_bit == 10'h000 && sda_oe_n) else $error("reset state wrong");
    a_en_in_frame: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(per_output_enable_bit) |-> idle_q < 6'h18) else $error("enables changed outside frame");
    a_ack_one_bit: assert property (@(negedge scl) disable iff (rst)
        $fell(sda_oe_n) |=> sda_oe_n) else $error("ack not one bit");
    a_byte_spacing: assert property (@(negedge scl) disable iff (rst)
        $rose(sda_oe_n) |-> sda_oe_n[*8]) else $error("ack spacing not eight bits");

    c_ack: cover property (@(negedge scl) disable iff (rst) $fell(sda_oe_n));
    c_en: cover property (@(posedge ref_clk) disable iff (rst) $changed(per_output_enable_bit));
    c_tri: cover property (@(posedge ref_clk) disable iff (rst) !output_enable);
endmodule : cbw_properties

bind cbw_top cbw_properties cbw_properties_inst (.ref_clk, .rst, .scl, .sda_in, .sda_out, .sda_oe_n, .buf_in,
    .output_enable, .fanout_clock_outputs, .fanout_clock_outputs_oe_n, .per_output_enable_bit, .frame_busy);

// ---- cbw_ctl_model.sv ----
// Bus controller model issuing block writes, 30 ns link clock.
// Assumes the bench resolves the pulled-up data line.
`timescale 1ns/100ps

module cbw_ctl_model (
    output logic      scl,     // Link clock, idle high
    output logic      sda_drv, // Low pulls data line
    input  wire logic sda      // Resolved line level
);
    // Bus idle, clock stands high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Start, bytes MSB first with ack bit, stop
    task automatic frame(input logic [7:0] q[$], output int acks);
        acks = 0;
        #15 sda_drv = 1'b0;
        #15 scl = 1'b0;
        foreach (q[k]) begin
            for (int i = 7; i >= -1; i--) begin
                #5 sda_drv = (i < 0) ? 1'b1 : q[k][i];
                #10 scl = 1'b1;
                if (i < 0 && sda === 1'b0) acks++;
                #15 scl = 1'b0;
            end
        end
        #5 sda_drv = 1'b0;
        #10 scl = 1'b1;
        #15 sda_drv = 1'b1;
    endtask : frame
endmodule : cbw_ctl_model

// ---- tb.sv ----
// Self-checking bench for the block-write slave.
// Assumes cbw_top, the controller model and the checker are compiled first.
`timescale 1ns/100ps

module tb;
    logic       ref_clk, rst, buf_in, output_enable, scl, sda_drv, sda_out, sda_oe_n, frame_busy;
    logic [9:0] outs, outs_oe_n, en;
    wire        sda = sda_drv & (sda_oe_n | sda_out);
    int         errors, n_tests, bdiv;

    cbw_top cbw_top_inst (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .buf_in(buf_in), .output_enable(output_enable), .fanout_clock_outputs(outs),
        .fanout_clock_outputs_oe_n(outs_oe_n), .per_output_enable_bit(en), .frame_busy(frame_busy));
    cbw_ctl_model cbw_ctl_model_inst (.scl(scl), .sda_drv(sda_drv), .sda(sda));

    // System clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Fanned clock, six system cycles a half period
    always @(posedge ref_clk) begin
        if (rst) begin
            bdiv   <= 0;
            buf_in <= 1'b0;
        end else begin
            bdiv <= (bdiv == 5) ? 0 : bdiv + 1;
            if (bdiv == 5) buf_in <= ~buf_in;
        end
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Send a frame, count acks, let enables settle
    task automatic send(input logic [7:0] q[$], input int n_ack, input logic [9:0] exp);
        int a;
        cbw_ctl_model_inst.frame(q, a);
        chk(a[9:0], n_ack[9:0], "ack count");
        repeat (40) @(posedge ref_clk);
        chk(en, exp, "enables");
        chk({9'h000, frame_busy}, 10'h000, "busy after stop");
    endtask : send

    task automatic t_full;
        send('{8'hD2, 8'h00, 8'h03, 8'h05, 8'hA0, 8'h40}, 6, 10'h1A5);
        repeat (4) begin
            @(negedge ref_clk);
            chk(outs, 10'h1A5 & {10{buf_in}}, "gated outputs");
            repeat (3) @(posedge ref_clk);
        end
        $display("full write done");
    endtask : t_full

    task automatic t_partial;
        send('{8'hD2, 8'h00, 8'h03, 8'h0A}, 4, 10'h1AA);
        $display("partial write done");
    endtask : t_partial

    task automatic t_extra;
        send('{8'hD2, 8'h00, 8'h04, 8'h03, 8'h50, 8'h80, 8'hFF}, 7, 10'h253);
        $display("extra bytes done");
    endtask : t_extra

    task automatic t_refused;
        send('{8'hD0, 8'h00, 8'h01, 8'h0F}, 0, 10'h253);
        send('{8'hD3, 8'h00, 8'h01, 8'h0F}, 0, 10'h253);
        $display("refused frames done");
    endtask : t_refused

    task automatic t_tristate;
        chk(outs_oe_n, 10'h000, "driven");
        output_enable <= 1'b0;
        @(negedge ref_clk);
        chk(outs_oe_n, 10'h3FF, "floated");
        @(posedge ref_clk);
        output_enable <= 1'b1;
        $display("tristate done");
    endtask : t_tristate

    // Main sequence
    initial begin
        rst = 1'b1;
        output_enable = 1'b1;
        errors = 0;
        n_tests = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(en, 10'h000, "reset enables");
        chk({9'h000, sda_oe_n}, 10'h001, "reset ack");
        t_full;
        t_partial;
        t_extra;
        t_refused;
        t_tristate;
        end_sim;
    end
endmodule : tb
